// File: design/clock_fanout_mux_sync_enable.sv
/*
  Clock fanout selector: picks the differential or the single-ended
  clock, retimes the active-low enable on the selected clock's falling
  edge and drives five true/complement output pairs.
  Assumes all pin levels are sampled synchronously to clk; each pin
  comes with a driven flag so that an open pin takes its default.
*/
`timescale 1ns/10ps
`default_nettype none
`include "clock_fanout_regs.svh"

module clock_fanout_mux_sync_enable #(
  parameter int PAIRS = `FANOUT_PAIRS
) (
  input wire logic clk,
  input wire logic resetn,
  input wire clock_fanout_pkg::diff_pin_s diff_clock_in,
  input wire clock_fanout_pkg::pin_s single_clock_in,
  input wire clock_fanout_pkg::pin_s select_in,
  input wire clock_fanout_pkg::pin_s enable_n_in,
  output var clock_fanout_pkg::pair_s fanout_pair_a,
  output var clock_fanout_pkg::pair_s fanout_pair_b,
  output var clock_fanout_pkg::pair_s fanout_pair_c,
  output var clock_fanout_pkg::pair_s fanout_pair_d,
  output var clock_fanout_pkg::pair_s fanout_pair_e
);

  logic diff_true;
  logic diff_inv;
  logic diff_level;
  logic diff_level_q;
  logic single_level;
  logic sel_level;
  logic enable_n;
  clock_fanout_pkg::src_e src;
  logic level;
  logic level_q;
  logic fall_edge;
  logic gate_en_q;
  logic gate_en_d;
  clock_fanout_pkg::pair_s pairs [PAIRS];

  // ----------------------------------------------------------------
  // Open-pin resolution
  // ----------------------------------------------------------------
  always_comb begin
    single_level = single_clock_in.driven ? single_clock_in.level : `SINGLE_OPEN_LVL;
    diff_true = diff_clock_in.true_driven ? diff_clock_in.true_lvl : `DIFF_TRUE_OPEN_LVL;
    diff_inv = diff_clock_in.inv_driven ? diff_clock_in.inv_lvl : `DIFF_INV_OPEN_LVL;
    sel_level = select_in.driven ? select_in.level : `SEL_OPEN_LVL;
    enable_n = enable_n_in.driven ? enable_n_in.level : `ENABLE_N_OPEN_LVL;
  end

  // ----------------------------------------------------------------
  // Differential decode
  // ----------------------------------------------------------------
  // Equal legs carry no information; the last decoded level is kept
  always_comb begin
    if (diff_true != diff_inv) begin
      diff_level = diff_true;
    end else begin
      diff_level = diff_level_q;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      diff_level_q <= `LEVEL_RST;
    end else begin
      diff_level_q <= diff_level;
    end
  end

  // ----------------------------------------------------------------
  // Input selection
  // ----------------------------------------------------------------
  always_comb begin
    src = clock_fanout_pkg::src_e'(sel_level);
    case (src)
      clock_fanout_pkg::SRC_DIFF: level = diff_level;
      clock_fanout_pkg::SRC_SINGLE: level = single_level;
      default: level = diff_level;
    endcase
  end

  // ----------------------------------------------------------------
  // Falling-edge detect on the selected clock
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      level_q <= `LEVEL_RST;
    end else begin
      level_q <= level;
    end
  end

  assign fall_edge = level_q & ~level;

  // ----------------------------------------------------------------
  // Enable retiming
  // ----------------------------------------------------------------
  // Captured only when the selected level has just gone low, so the
  // gate never cuts a high phase short
  always_comb begin
    gate_en_d = gate_en_q;
    if (fall_edge) begin
      gate_en_d = ~enable_n;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gate_en_q <= `GATE_EN_RST;
    end else begin
      gate_en_q <= gate_en_d;
    end
  end

  // ----------------------------------------------------------------
  // Output pairs
  // ----------------------------------------------------------------
  for (genvar i = 0; i < PAIRS; i++) begin : g_pair
    fanout_pair_driver u_pair (
      .clk(clk),
      .resetn(resetn),
      .level(level),
      .gate_en(gate_en_q),
      .pair_out(pairs[i])
    );
  end

  assign fanout_pair_a = pairs[0];
  assign fanout_pair_b = pairs[1];
  assign fanout_pair_c = pairs[2];
  assign fanout_pair_d = pairs[3];
  assign fanout_pair_e = pairs[4];

endmodule

`default_nettype wire

// File: design/clock_fanout_regs.svh
/*
  Constants for the clock fanout selector: open-pin default levels,
  reset values and the number of output pairs.
  Assumes inclusion by bare name from design files; definitions only.
*/
`ifndef CLOCK_FANOUT_REGS_SVH
`define CLOCK_FANOUT_REGS_SVH

// ----------------------------------------------------------------
// Open-pin default levels
// ----------------------------------------------------------------
`define SEL_OPEN_LVL 1'h0
`define ENABLE_N_OPEN_LVL 1'h0
`define SINGLE_OPEN_LVL 1'h0
`define DIFF_TRUE_OPEN_LVL 1'h0
`define DIFF_INV_OPEN_LVL 1'h1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define GATE_EN_RST 1'h0
`define LEVEL_RST 1'h0
`define PAIR_TRUE_RST 1'h0
`define PAIR_COMP_RST 1'h1

// ----------------------------------------------------------------
// Structure
// ----------------------------------------------------------------
`define FANOUT_PAIRS 5

`endif

// File: design/clock_fanout_pkg.sv
/*
  Types shared by the clock fanout selector and its pair driver.
  Assumes nothing of its surroundings.
*/
package clock_fanout_pkg;

  // One sampled pin and whether anything drives it
  typedef struct packed {
    logic level;
    logic driven;
  } pin_s;

  // Both legs of a differential input pair
  typedef struct packed {
    logic true_lvl;
    logic true_driven;
    logic inv_lvl;
    logic inv_driven;
  } diff_pin_s;

  // One output pair: true line and its complement
  typedef struct packed {
    logic true_lvl;
    logic comp_lvl;
  } pair_s;

  typedef enum logic [0:0] {
    SRC_DIFF   = 1'h0,
    SRC_SINGLE = 1'h1
  } src_e;

endpackage

// File: design/fanout_pair_driver.sv
/*
  One registered output pair: true line carries the gated clock level,
  complement line is always its inverse.
  Assumes the gate only changes while the level is low.
*/
`timescale 1ns/10ps
`default_nettype none
`include "clock_fanout_regs.svh"

module fanout_pair_driver (
  input wire logic clk,
  input wire logic resetn,
  input wire logic level,
  input wire logic gate_en,
  output var clock_fanout_pkg::pair_s pair_out
);

  logic true_d;

  // ----------------------------------------------------------------
  // Gated level and complement
  // ----------------------------------------------------------------
  always_comb begin
    true_d = gate_en & level;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pair_out.true_lvl <= `PAIR_TRUE_RST;
      pair_out.comp_lvl <= `PAIR_COMP_RST;
    end else begin
      pair_out.true_lvl <= true_d;
      pair_out.comp_lvl <= ~true_d;
    end
  end

endmodule

`default_nettype wire

// File: verif/clock_fanout_monitor.sv
/* Checker of the fanout pair outputs.
   Bound to the top module; sees its ports only. */
`timescale 1ns/10ps
`default_nettype none
module clock_fanout_monitor #(
  parameter int PAIRS = 5
) (
  input wire logic clk,
  input wire logic resetn,
  input wire clock_fanout_pkg::diff_pin_s diff_clock_in,
  input wire clock_fanout_pkg::pin_s single_clock_in,
  input wire clock_fanout_pkg::pin_s select_in,
  input wire clock_fanout_pkg::pin_s enable_n_in,
  input wire clock_fanout_pkg::pair_s fanout_pair_a,
  input wire clock_fanout_pkg::pair_s fanout_pair_b,
  input wire clock_fanout_pkg::pair_s fanout_pair_c,
  input wire clock_fanout_pkg::pair_s fanout_pair_d,
  input wire clock_fanout_pkg::pair_s fanout_pair_e
);
  logic sel, lv, en, t, dt, st;
  assign sel = select_in.driven & select_in.level;
  assign dt = diff_clock_in.true_driven & diff_clock_in.true_lvl;
  assign st = single_clock_in.driven & single_clock_in.level;
  assign lv = sel ? st : dt;
  assign en = !(enable_n_in.driven & enable_n_in.level);
  assign t = fanout_pair_a.true_lvl;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence fall_s; $past(resetn) && $past(lv) && !lv; endsequence
  sequence off_s; fall_s ##0 !en; endsequence
  sequence on_s; fall_s ##0 en ##1 lv; endsequence
  AST_COMP: assert property (fanout_pair_a.comp_lvl == !t)
    else $error("complement wrong");
  AST_SAME: assert property (fanout_pair_b == fanout_pair_a && fanout_pair_c == fanout_pair_a
    && fanout_pair_d == fanout_pair_a && fanout_pair_e == fanout_pair_a) else $error("pairs differ");
  AST_OFF: assert property (off_s |-> ##2 !t) else $error("not disabled");
  AST_STAY: assert property (off_s ##1 (lv || !$past(lv))[*2] |=> !t)
    else $error("disable lost");
  AST_ON: assert property (on_s |=> t) else $error("not enabled");
  AST_RUNT: assert property ($changed(t) |-> $past(lv) == t) else $error("runt edge");
  AST_DIFF: assert property (t && !$past(sel) |->
    $past(dt)) else $error("diff route");
  AST_SING: assert property (t && $past(sel) |->
    $past(st)) else $error("single route");
endmodule
`default_nettype wire

// File: verif/clock_source_model.sv
/* Source model for both clock inputs.
   Open legs rest at their pull levels: true legs low, inverted leg high. */
`timescale 1ns/10ps
`default_nettype none
module clock_source_model (
  input wire logic clk,
  input wire logic [1:0] drv,
  output wire clock_fanout_pkg::diff_pin_s dif,
  output wire clock_fanout_pkg::pin_s sgl
);
  logic [1:0] ph = 2'h0;
  always @(posedge clk) ph <= ph + 2'h1;
  assign dif = '{drv[0] & ph[0], drv[0], ~(drv[0] & ph[0]), drv[0]};
  assign sgl = '{drv[1] & ph[1], drv[1]};
endmodule
`default_nettype wire

// File: verif/clock_fanout_mux_sync_enable_test.sv
/* Testbench of the clock fanout selector.
   Uses the source model and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
module clock_fanout_mux_sync_enable_test;
  logic clk, resetn, lv_q, gate_q, l, e;
  logic [1:0] drv;
  logic [31:0] r;
  int err_count = 0;
  int comparisons = 0;
  logic q[$];
  clock_fanout_pkg::diff_pin_s dif;
  clock_fanout_pkg::pin_s sgl, sel, enn;
  clock_fanout_pkg::pair_s pa, pb, pc, pd, pe;
  clock_source_model src (.clk(clk), .drv(drv), .dif(dif), .sgl(sgl));
  clock_fanout_mux_sync_enable uut (.clk(clk), .resetn(resetn), .diff_clock_in(dif), .single_clock_in(sgl),
    .select_in(sel), .enable_n_in(enn), .fanout_pair_a(pa), .fanout_pair_b(pb), .fanout_pair_c(pc),
    .fanout_pair_d(pd), .fanout_pair_e(pe));
  assign l = (sel.driven & sel.level) ? sgl.driven & sgl.level : dif.true_driven & dif.true_lvl;
  always @(posedge clk or negedge resetn)
    if (!resetn) begin
      lv_q <= 1'h0;
      gate_q <= 1'h0;
      q.delete();
    end else begin
      q.push_back(gate_q & l);
      if (lv_q & !l) gate_q <= !(enn.driven & enn.level);
      lv_q <= l;
    end
  task check(input logic [9:0] seen, input logic [9:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  always @(negedge clk)
    if (!resetn) check({pa, pb, pc, pd, pe}, 10'h155);
    else if (q.size() > 0) begin
      e = q.pop_front();
      check({pa, pb, pc, pd, pe}, {5{e, !e}});
    end
  task end_of_test;
    if (err_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task do_reset;
    resetn <= 1'h0;
    repeat (10) @(posedge clk);
    resetn <= 1'h1;
  endtask
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  initial begin
    #200000;
    err_count++;
    end_of_test();
  end
  initial begin
    resetn = 1'h0;
    sel = '0;
    enn = '0;
    drv = 2'h3;
    r = $urandom(32'h5B133E96);
    do_reset();
    for (int k = 0; k < 16; k++) begin
      if (k == 8) do_reset();
      repeat (100) begin
        @(posedge clk);
        r = $urandom;
        sel <= '{k[1] ? (k[0] ? r[0] : 1'h1) : (!k[0] & r[0]), k[1] | k[0]};
        enn <= '{r[1] & r[2] & (k[3] | !r[3]), k[3] | r[3]};
        drv <= k[2] ? r[5:4] : 2'h3;
      end
    end
    end_of_test();
  end
endmodule
bind clock_fanout_mux_sync_enable clock_fanout_monitor #(.PAIRS(PAIRS)) mon (.clk(clk), .resetn(resetn),
  .diff_clock_in(diff_clock_in), .single_clock_in(single_clock_in), .select_in(select_in),
  .enable_n_in(enable_n_in), .fanout_pair_a(fanout_pair_a), .fanout_pair_b(fanout_pair_b),
  .fanout_pair_c(fanout_pair_c), .fanout_pair_d(fanout_pair_d), .fanout_pair_e(fanout_pair_e));
`default_nettype wire
